// *** design/rmsc_controller.v ***
/*
 * radio main state controller: moves the device between its operating
 * states on one-byte commands delivered by an spi front end.
 * assumes cmd_valid_in pulses once per completed command byte that followed
 * the 0x80 prefix byte, all inputs synchronous to mclk_in.
 */
`timescale 1ns/1ps
`include "rmsc_defines.vh"

module rmsc_controller #(
    parameter integer CLK_MHZ      = `RMSC_CLK_MHZ,
    parameter integer POWERUP_CYC  = `RMSC_T_POWERUP_US * `RMSC_CLK_MHZ,
    parameter integer RAMP_CYC     = 16
) (
    input  wire       mclk_in,
    input  wire       srst_in,
    input  wire       shutdown_pin_in,
    input  wire       cmd_valid_in,
    input  wire [7:0] cmd_code_in,
    input  wire       sleep_retain_sel_in,
    input  wire       vco_cal_en_in,
    input  wire       pa_ramp_en_in,
    input  wire       ext_sleep_req_in,
    input  wire       ext_wake_req_in,
    output reg  [7:0] state_code_out,
    output reg        ref_clock_on_out,
    output reg        synth_on_out,
    output reg        wakeup_timer_on_out,
    output reg        synth_tx_cfg_out,
    output reg        preamble_start_out,
    output reg        soft_reset_cmd_out,
    output reg        receive_fifo_clear_cmd_out,
    output reg        transmit_fifo_clear_cmd_out,
    output reg        duty_timer_reload_cmd_out,
    output reg        seq_reload_cmd_out,
    output reg        cmd_ignored_out
);

    ////////////////////////////////////////////////////////////////////////////
    // timing counts, rounded to whole cycles
    localparam integer DOWN_CYC     = `RMSC_T_DOWN_US * CLK_MHZ;
    localparam integer LOCK_CYC     = `RMSC_T_LOCK_US * CLK_MHZ;
    localparam integer LOCK_CAL_CYC = `RMSC_T_LOCK_CAL_US * CLK_MHZ;
    localparam integer EXIT_CYC     = `RMSC_T_EXIT_US * CLK_MHZ;
    localparam integer WAKE_CYC     = `RMSC_T_WAKE_US * CLK_MHZ;
    localparam integer LRUN_CYC     = `RMSC_T_LOCK_RUN_US * CLK_MHZ;

    // one-hot states; setup covers any timed move
    localparam [8:0] S_OFF     = 9'h001;
    localparam [8:0] S_READY   = 9'h002;
    localparam [8:0] S_STANDBY = 9'h004;
    localparam [8:0] S_SLEEP_A = 9'h008;
    localparam [8:0] S_SLEEP_B = 9'h010;
    localparam [8:0] S_LOCK    = 9'h020;
    localparam [8:0] S_RX      = 9'h040;
    localparam [8:0] S_TX      = 9'h080;
    localparam [8:0] S_SETUP   = 9'h100;

    reg  [8:0]  state_r;
    reg  [8:0]  state_nxt;
    reg  [8:0]  target_r;
    reg  [8:0]  target_nxt;
    reg  [8:0]  final_r;
    reg  [8:0]  final_nxt;
    reg  [15:0] wait_r;
    reg  [15:0] wait_nxt;
    reg         tx_cfg_r;
    reg         tx_cfg_nxt;
    reg  [15:0] ramp_r;
    reg         ignored_nxt;
    reg         sdn_seen_r;

    // nothing is taken while shutdown holds the device off
    wire        cmd_go = cmd_valid_in & ~shutdown_pin_in;
    wire [15:0] lock_time = vco_cal_en_in ? LOCK_CAL_CYC[15:0] : LOCK_CYC[15:0];
    wire [8:0]  sleep_state = sleep_retain_sel_in ? S_SLEEP_B : S_SLEEP_A;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always @* begin
        state_nxt   = state_r;
        target_nxt  = target_r;
        final_nxt   = final_r;
        wait_nxt    = (wait_r != 16'h0000) ? wait_r - 16'h0001 : 16'h0000;
        tx_cfg_nxt  = tx_cfg_r;
        ignored_nxt = 1'b0;
        case (state_r)
            S_OFF: begin
                if (!shutdown_pin_in && sdn_seen_r) begin
                    state_nxt  = S_SETUP;
                    target_nxt = S_READY;
                    final_nxt  = S_READY;
                    wait_nxt   = POWERUP_CYC[15:0];
                end
            end
            S_SETUP: begin
                // each countdown ends the move or hands on to the next one, so this state stays transient
                if (wait_r <= 16'h0001) begin
                    // ready and lock hand on when a later target waits
                    if (target_r == final_r) begin
                        state_nxt = final_r;
                    end else if (target_r == S_READY) begin
                        state_nxt  = S_SETUP;
                        target_nxt = S_LOCK;
                        wait_nxt   = lock_time;
                    end else begin
                        state_nxt  = S_SETUP;
                        target_nxt = final_r;
                        wait_nxt   = LRUN_CYC[15:0];
                    end
                end
            end
            S_READY: begin
                // a duty-cycle or csma sleep request wins over any command but soft reset
                if (ext_sleep_req_in) begin
                    state_nxt  = S_SETUP;
                    target_nxt = sleep_state;
                    final_nxt  = sleep_state;
                    wait_nxt   = DOWN_CYC[15:0];
                end else if (cmd_go) begin
                    case (cmd_code_in)
                        `RMSC_CMD_TX, `RMSC_CMD_RX: begin
                            tx_cfg_nxt = (cmd_code_in == `RMSC_CMD_TX);
                            state_nxt  = S_SETUP;
                            target_nxt = S_LOCK;
                            final_nxt  = (cmd_code_in == `RMSC_CMD_TX) ? S_TX : S_RX;
                            wait_nxt   = lock_time;
                        end
                        `RMSC_CMD_LOCK_RX, `RMSC_CMD_LOCK_TX: begin
                            tx_cfg_nxt = (cmd_code_in == `RMSC_CMD_LOCK_TX);
                            state_nxt  = S_SETUP;
                            target_nxt = S_LOCK;
                            final_nxt  = S_LOCK;
                            wait_nxt   = lock_time;
                        end
                        `RMSC_CMD_STANDBY, `RMSC_CMD_SLEEP: begin
                            state_nxt  = S_SETUP;
                            target_nxt = (cmd_code_in == `RMSC_CMD_SLEEP) ? sleep_state
                                                                          : S_STANDBY;
                            final_nxt  = target_nxt;
                            wait_nxt   = DOWN_CYC[15:0];
                        end
                        `RMSC_CMD_READY, `RMSC_CMD_ABORT: ignored_nxt = 1'b1;
                        default: ;
                    endcase
                end
            end
            // stable states leave only on the ready or soft reset command, or the wake timer in sleep
            S_STANDBY, S_SLEEP_A, S_SLEEP_B, S_LOCK: begin
                if ((cmd_go && cmd_code_in == `RMSC_CMD_READY)
                        || (ext_wake_req_in && state_r != S_STANDBY
                            && state_r != S_LOCK)) begin
                    state_nxt  = S_SETUP;
                    target_nxt = S_READY;
                    final_nxt  = S_READY;
                    wait_nxt   = (state_r == S_LOCK) ? EXIT_CYC[15:0] : WAKE_CYC[15:0];
                end else if (cmd_go && cmd_code_in >= `RMSC_CMD_TX
                             && cmd_code_in <= `RMSC_CMD_ABORT) begin
                    ignored_nxt = 1'b1;
                end
            end
            S_RX, S_TX: begin
                if (cmd_go && cmd_code_in == `RMSC_CMD_ABORT) begin
                    state_nxt  = S_SETUP;
                    target_nxt = S_READY;
                    final_nxt  = S_READY;
                    wait_nxt   = EXIT_CYC[15:0];
                end else if (cmd_go && ((state_r == S_RX && cmd_code_in == `RMSC_CMD_TX)
                             || (state_r == S_TX && cmd_code_in == `RMSC_CMD_RX))) begin
                    // swap goes back through lock on one command
                    tx_cfg_nxt = (cmd_code_in == `RMSC_CMD_TX);
                    state_nxt  = S_SETUP;
                    target_nxt = S_LOCK;
                    final_nxt  = (cmd_code_in == `RMSC_CMD_TX) ? S_TX : S_RX;
                    wait_nxt   = lock_time;
                end else if (cmd_go && cmd_code_in >= `RMSC_CMD_TX
                             && cmd_code_in <= `RMSC_CMD_ABORT) begin
                    ignored_nxt = 1'b1;
                end
            end
            default: state_nxt = S_OFF;
        endcase
        // state commands in the middle of a timed move are refused
        if (cmd_go && state_r == S_SETUP && cmd_code_in >= `RMSC_CMD_TX
                && cmd_code_in <= `RMSC_CMD_ABORT) begin
            ignored_nxt = 1'b1;
        end
        // soft reset overrides any move in progress
        if (cmd_go && cmd_code_in == `RMSC_CMD_SOFT_RESET) begin
            state_nxt  = S_SETUP;
            target_nxt = S_READY;
            final_nxt  = S_READY;
            wait_nxt   = EXIT_CYC[15:0];
            tx_cfg_nxt = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; shutdown clears everything except sdn_seen_r, which it sets
    always @(posedge mclk_in) begin
        if (srst_in || shutdown_pin_in) begin
            state_r    <= S_OFF;
            target_r   <= S_READY;
            final_r    <= S_READY;
            wait_r     <= 16'h0000;
            tx_cfg_r   <= 1'b0;
            // srst release idles one edge in off; a shutdown release leaves at once
            sdn_seen_r <= ~srst_in;
        end else begin
            state_r    <= state_nxt;
            target_r   <= target_nxt;
            final_r    <= final_nxt;
            wait_r     <= wait_nxt;
            tx_cfg_r   <= tx_cfg_nxt;
            sdn_seen_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always @(posedge mclk_in) begin
        if (srst_in || shutdown_pin_in) begin
            state_code_out              <= `RMSC_CODE_OFF;
            ref_clock_on_out            <= 1'b0;
            synth_on_out                <= 1'b0;
            wakeup_timer_on_out         <= 1'b0;
            synth_tx_cfg_out            <= 1'b0;
            preamble_start_out          <= 1'b0;
            ramp_r                      <= 16'h0000;
            soft_reset_cmd_out          <= 1'b0;
            receive_fifo_clear_cmd_out  <= 1'b0;
            transmit_fifo_clear_cmd_out <= 1'b0;
            duty_timer_reload_cmd_out   <= 1'b0;
            seq_reload_cmd_out          <= 1'b0;
            cmd_ignored_out             <= 1'b0;
        end else begin
            // codes follow the next state so they line up with state_r
            case (state_nxt)
                S_READY:   state_code_out <= `RMSC_CODE_READY;
                S_STANDBY: state_code_out <= `RMSC_CODE_STANDBY;
                S_SLEEP_A: state_code_out <= `RMSC_CODE_SLEEP_A;
                S_SLEEP_B: state_code_out <= `RMSC_CODE_SLEEP_B;
                S_LOCK:    state_code_out <= `RMSC_CODE_LOCK;
                S_RX:      state_code_out <= `RMSC_CODE_RX;
                S_TX:      state_code_out <= `RMSC_CODE_TX;
                S_SETUP:   state_code_out <= `RMSC_CODE_SETUP;
                default:   state_code_out <= `RMSC_CODE_OFF;
            endcase
            ref_clock_on_out    <= |(state_nxt & (S_READY | S_LOCK | S_RX | S_TX
                                                  | S_SETUP));
            synth_on_out        <= |(state_nxt & (S_LOCK | S_RX | S_TX | S_SETUP));
            wakeup_timer_on_out <= |(state_nxt & (S_SLEEP_A | S_SLEEP_B));
            synth_tx_cfg_out    <= tx_cfg_nxt;
            // preamble at transmit entry, or after the ramp time
            if (state_nxt != S_TX) begin
                ramp_r             <= 16'h0000;
                preamble_start_out <= 1'b0;
            end else if (state_r != S_TX) begin
                ramp_r             <= RAMP_CYC[15:0];
                preamble_start_out <= ~pa_ramp_en_in;
            end else begin
                ramp_r             <= (ramp_r != 16'h0000) ? ramp_r - 16'h0001 : 16'h0000;
                preamble_start_out <= pa_ramp_en_in && ramp_r == 16'h0001;
            end
            // plain sleep entry empties both fifos
            receive_fifo_clear_cmd_out  <= (cmd_go && cmd_code_in == `RMSC_CMD_RX_FLUSH)
                || (state_nxt == S_SLEEP_A && state_r != S_SLEEP_A);
            transmit_fifo_clear_cmd_out <= (cmd_go && cmd_code_in == `RMSC_CMD_TX_FLUSH)
                || (state_nxt == S_SLEEP_A && state_r != S_SLEEP_A);
            // any-state commands pulse for one cycle, also during setup
            soft_reset_cmd_out        <= cmd_go && cmd_code_in == `RMSC_CMD_SOFT_RESET;
            duty_timer_reload_cmd_out <= cmd_go
                && cmd_code_in == `RMSC_CMD_DUTY_RELOAD;
            seq_reload_cmd_out        <= cmd_go
                && cmd_code_in == `RMSC_CMD_SEQ_RELOAD;
            cmd_ignored_out           <= ignored_nxt;
        end
    end

endmodule

// *** design/rmsc_defines.vh ***
/*
 * constants for the radio main state controller: command codes, state codes
 * and transition times. assumes inclusion by bare name from design files.
 */
`ifndef RMSC_DEFINES_VH
`define RMSC_DEFINES_VH

`define RMSC_CMD_PREFIX      8'h80
`define RMSC_CMD_TX          8'h60
`define RMSC_CMD_RX          8'h61
`define RMSC_CMD_READY       8'h62
`define RMSC_CMD_STANDBY     8'h63
`define RMSC_CMD_SLEEP       8'h64
`define RMSC_CMD_LOCK_RX     8'h65
`define RMSC_CMD_LOCK_TX     8'h66
`define RMSC_CMD_ABORT       8'h67
`define RMSC_CMD_DUTY_RELOAD 8'h68
`define RMSC_CMD_SOFT_RESET  8'h70
`define RMSC_CMD_RX_FLUSH    8'h71
`define RMSC_CMD_TX_FLUSH    8'h72
`define RMSC_CMD_SEQ_RELOAD  8'h73

`define RMSC_CODE_READY      8'h00
`define RMSC_CODE_LOCK       8'h0c
`define RMSC_CODE_RX         8'h30
`define RMSC_CODE_TX         8'h5c
`define RMSC_CODE_STANDBY    8'h02
`define RMSC_CODE_SLEEP_A    8'h01
`define RMSC_CODE_SLEEP_B    8'h03
`define RMSC_CODE_SETUP      8'h50
`define RMSC_CODE_OFF        8'hff

`define RMSC_CLK_MHZ         10
`define RMSC_T_POWERUP_US    500
`define RMSC_T_DOWN_US       3
`define RMSC_T_LOCK_US       70
`define RMSC_T_LOCK_CAL_US   85
`define RMSC_T_EXIT_US       1
`define RMSC_T_WAKE_US       100
`define RMSC_T_LOCK_RUN_US   26

`endif

// *** tb/rmsc_sva.sv ***
/* checker for rmsc_controller: state codes, state outputs, command effects.
   bound to every rmsc_controller; sees its ports only. */
`timescale 1ns/1ps
module rmsc_sva (
    input logic       mclk_in,
    input logic       srst_in,
    input logic       shutdown_pin_in,
    input logic       cmd_valid_in,
    input logic [7:0] cmd_code_in,
    input logic       sleep_retain_sel_in,
    input logic [7:0] state_code_out,
    input logic       ref_clock_on_out,
    input logic       synth_on_out,
    input logic       wakeup_timer_on_out,
    input logic       synth_tx_cfg_out,
    input logic       soft_reset_cmd_out,
    input logic       duty_timer_reload_cmd_out,
    input logic       seq_reload_cmd_out,
    input logic       cmd_ignored_out
);
default clocking cb @(posedge mclk_in); endclocking
default disable iff (srst_in);
wire [7:0] sc;
wire       cmd_ok;
assign sc = state_code_out;
assign cmd_ok = cmd_valid_in && !shutdown_pin_in;
////////////////////////////////////////
a_code_legal: assert property (sc inside {8'h00, 8'h0c, 8'h30, 8'h5c, 8'h02, 8'h01, 8'h03,
    8'h50, 8'hff}) else $error("state code outside the legal set");
a_ready_clock: assert property (sc == 8'h00 |-> ref_clock_on_out && !synth_on_out)
    else $error("ready without reference clock");
a_low_power: assert property (sc inside {8'h01, 8'h02, 8'h03} |->
    !ref_clock_on_out && !synth_on_out) else $error("oscillator on in low power state");
a_sleep_timer: assert property (sc inside {8'h01, 8'h03} |-> wakeup_timer_on_out)
    else $error("wake timer off in sleep");
a_radio_via_lock: assert property (sc inside {8'h30, 8'h5c} && $past(sc) != sc |->
    $past(sc) == 8'h50) else $error("radio state entered without lock");
a_tx_from_ready: assert property (cmd_ok && cmd_code_in == 8'h60 && sc == 8'h00 |=>
    sc == 8'h50 && synth_tx_cfg_out) else $error("transmit command not started");
a_abort_exit: assert property (cmd_ok && cmd_code_in == 8'h67 && sc inside {8'h30, 8'h5c}
    |=> sc == 8'h50 ##[1:12] sc == 8'h00) else $error("abort did not reach ready");
a_sleep_variant: assert property (sc inside {8'h01, 8'h03} && $past(sc) == 8'h50 |->
    sc == (sleep_retain_sel_in ? 8'h03 : 8'h01)) else $error("wrong sleep variant");
a_ignore_hold: assert property (cmd_ignored_out |-> sc == $past(sc))
    else $error("refused command changed state");
a_reset_pulse: assert property (cmd_ok && cmd_code_in == 8'h70 && sc != 8'hff |=>
    soft_reset_cmd_out) else $error("soft reset not signalled");
a_reload_pulse: assert property (cmd_ok && cmd_code_in == 8'h68 && sc != 8'hff |=>
    duty_timer_reload_cmd_out) else $error("duty timer reload not signalled");
a_seq_pulse: assert property (cmd_ok && cmd_code_in == 8'h73 && sc != 8'hff |=>
    seq_reload_cmd_out) else $error("sequence reload not signalled");
a_shutdown_off: assert property (shutdown_pin_in |=> sc == 8'hff)
    else $error("state kept while shut down");
endmodule
bind rmsc_controller rmsc_sva u_sva (.mclk_in, .srst_in, .shutdown_pin_in, .cmd_valid_in,
    .cmd_code_in, .sleep_retain_sel_in, .state_code_out, .ref_clock_on_out, .synth_on_out,
    .wakeup_timer_on_out, .synth_tx_cfg_out, .soft_reset_cmd_out, .duty_timer_reload_cmd_out,
    .seq_reload_cmd_out, .cmd_ignored_out);

// *** tb/rmsc_host_model.sv ***
/* host side: hands over decoded command bytes, one pulse per command.
   assumes the spi decoder between host and controller strips the prefix. */
`timescale 1ns/1ps
module rmsc_host_model (
    input  logic       mclk_in,
    output logic       cmd_valid_out,
    output logic [7:0] cmd_code_out
);
initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out = 8'h00;
end
// gap gives slow or prompt delivery; the byte stands for prefix 0x80 plus code
task automatic send(input logic [7:0] code, input int gap);
    repeat (gap) @(posedge mclk_in);
    @(posedge mclk_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out <= code;
    @(posedge mclk_in);
    cmd_valid_out <= 1'b0;
    cmd_code_out <= ~code;
    @(negedge mclk_in);
endtask
endmodule

// *** tb/testbench.sv ***
/* self-checking bench for rmsc_controller: state changes checked from a queue.
   assumes a 10 MHz clock and a shortened power-up count. */
`timescale 1ns/1ps
module testbench;
localparam int RAMP = 16;
logic       mclk_in, srst_in, shutdown_pin, sel, vco, ramp, xsl, xwk, mon_on;
wire        cmd_v, rck, syn, wkt, txc, pre, srs, rxf, txf, dtr, seq, ign;
wire  [7:0] cmd_c, sc;
logic [7:0] exp_q[$];
logic [7:0] prev_c;
logic [7:0] any_cmd [5] = '{8'h68, 8'h71, 8'h72, 8'h73, 8'h70};
logic [15:0] fclr_n;
int         n_mismatch, checks_done, n, seed, i;
rmsc_host_model host (.mclk_in(mclk_in), .cmd_valid_out(cmd_v), .cmd_code_out(cmd_c));
rmsc_controller #(.POWERUP_CYC(20), .RAMP_CYC(RAMP)) DUT (.mclk_in(mclk_in),
    .srst_in(srst_in), .shutdown_pin_in(shutdown_pin), .cmd_valid_in(cmd_v), .cmd_code_in(cmd_c),
    .sleep_retain_sel_in(sel), .vco_cal_en_in(vco), .pa_ramp_en_in(ramp),
    .ext_sleep_req_in(xsl), .ext_wake_req_in(xwk), .state_code_out(sc),
    .ref_clock_on_out(rck), .synth_on_out(syn), .wakeup_timer_on_out(wkt),
    .synth_tx_cfg_out(txc), .preamble_start_out(pre), .soft_reset_cmd_out(srs),
    .receive_fifo_clear_cmd_out(rxf), .transmit_fifo_clear_cmd_out(txf),
    .duty_timer_reload_cmd_out(dtr), .seq_reload_cmd_out(seq), .cmd_ignored_out(ign));
initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
end
////////////////////////////////////////
task automatic bad(input logic [15:0] e, input logic [15:0] g);
    n_mismatch++;
    $display("BAD t=%0t exp=%h got=%h", $time, e, g);
endtask
task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (e !== g) bad(e, g);
endtask
task automatic rng(input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi) bad(lo[15:0], v[15:0]);
endtask
task automatic wait_code(input logic [7:0] c, input int max, output int k);
    k = 0;
    while (sc !== c && k < max) begin
        @(negedge mclk_in);
        k++;
    end
    chk(c, sc);
endtask
task automatic wait_pre(output int k);
    k = 0;
    while (pre !== 1'b1 && k < 40) begin
        @(negedge mclk_in);
        k++;
    end
endtask
task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask
// every state change takes the oldest expected code
always @(posedge mclk_in) begin
    if (mon_on && sc !== prev_c) begin
        if (exp_q.size() == 0) bad(prev_c, sc);
        else chk(exp_q.pop_front(), sc);
    end
    prev_c <= sc;
    if (rxf === 1'b1) fclr_n <= fclr_n + 16'h1;
end
initial begin
    #3000000;
    n_mismatch++;
    end_of_test();
end
initial begin
    {srst_in, shutdown_pin, sel, vco, ramp, xsl, xwk, mon_on} = 8'h80;
    seed = 59;
    fclr_n = 16'h0;
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    exp_q = {exp_q, 8'h50, 8'h00};
    @(negedge mclk_in);
    mon_on = 1'b1;
    wait_code(8'h00, 100, n);
    chk({rck, syn}, 2'b10);
    exp_q = {exp_q, 8'h50, 8'h5c};
    host.send(8'h60, 0);
    wait_code(8'h5c, 1100, n); rng(n, 955, 965);
    wait_pre(n); rng(n, 0, 1);
    exp_q = {exp_q, 8'h50, 8'h30};
    host.send(8'h61, 0);
    wait_code(8'h30, 1100, n); rng(n, 955, 965);
    exp_q = {exp_q, 8'h50, 8'h00};
    host.send(8'h67, 0);
    wait_code(8'h00, 30, n); rng(n, 8, 12);
    for (i = 0; i < 2; i++) begin
        host.send(i ? 8'h67 : 8'h62, i); chk(ign, 1'b1);
    end
    for (i = 0; i < 3; i++) begin
        host.send(8'h80 | 8'($random(seed)), 0); chk(ign, 1'b0);
    end
    $display("test radio states done");
    for (i = 0; i < 2; i++) begin
        @(posedge mclk_in) vco <= (i == 1);
        exp_q = {exp_q, 8'h50, 8'h0c};
        host.send(i ? 8'h66 : 8'h65, 0); chk(txc, i == 1);
        wait_code(8'h0c, 1000, n); rng(n, i ? 845 : 695, i ? 855 : 705);
        repeat (40) @(negedge mclk_in);
        exp_q = {exp_q, 8'h50, 8'h00};
        host.send(8'h62, 0); wait_code(8'h00, 30, n);
    end
    @(posedge mclk_in) vco <= 1'b0;
    exp_q = {exp_q, 8'h50, 8'h02};
    host.send(8'h63, 0); wait_code(8'h02, 60, n); rng(n, 27, 33);
    chk({rck, syn, wkt}, 3'b000);
    host.send(8'h60, 0); chk(ign, 1'b1);
    exp_q = {exp_q, 8'h50, 8'h00};
    host.send(8'h62, 0); wait_code(8'h00, 1100, n); rng(n, 995, 1005);
    $display("test lock and standby done");
    for (i = 0; i < 2; i++) begin
        @(posedge mclk_in) sel <= (i == 1);
        fclr_n <= 16'h0;
        exp_q = {exp_q, 8'h50, i ? 8'h03 : 8'h01};
        host.send(8'h64, 0); wait_code(i ? 8'h03 : 8'h01, 60, n);
        chk(wkt, 1'b1);
        exp_q = {exp_q, 8'h50, 8'h00};
        if (i == 0) host.send(8'h62, 0);
        else begin
            @(posedge mclk_in) xwk <= 1'b1;
            @(posedge mclk_in) xwk <= 1'b0;
        end
        wait_code(8'h00, 1100, n); chk(i ? 16'h0 : 16'h1, fclr_n);
    end
    exp_q = {exp_q, 8'h50, 8'h03};
    @(posedge mclk_in) xsl <= 1'b1;
    @(posedge mclk_in) xsl <= 1'b0;
    wait_code(8'h03, 60, n);
    exp_q = {exp_q, 8'h50, 8'h00};
    host.send(8'h62, 0); wait_code(8'h00, 1100, n);
    $display("test sleep done");
    @(posedge mclk_in) ramp <= 1'b1;
    exp_q = {exp_q, 8'h50, 8'h5c, 8'h50, 8'h00};
    host.send(8'h60, 0); wait_code(8'h5c, 1100, n);
    wait_pre(n); rng(n, RAMP - 1, RAMP + 1);
    for (i = 0; i < 5; i++) begin
        host.send(any_cmd[i], 0); chk(16'h10 >> i, {dtr, rxf, txf, seq, srs});
    end
    wait_code(8'h00, 30, n);
    exp_q = {exp_q, 8'hff, 8'h50, 8'h00};
    @(posedge mclk_in) shutdown_pin <= 1'b1;
    repeat (3) @(posedge mclk_in);
    shutdown_pin <= 1'b0;
    wait_code(8'h00, 100, n);
    $display("test commands and shutdown done");
    end_of_test();
end
endmodule
